// *** core/fpr_map.svh ***
// register offsets, field positions, reset values and timing counts of the flash register block
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH

`define FPR_ADDR_W          6
`define FPR_OFF_CONTROL     6'h00
`define FPR_OFF_KEY         6'h04
`define FPR_OFF_TARGET      6'h08
`define FPR_OFF_DATA        6'h0c
`define FPR_OFF_SOURCE      6'h10
`define FPR_OFF_IRQ_STATUS  6'h14
`define FPR_OFF_IRQ_MASK    6'h18

`define FPR_BIT_START       15
`define FPR_BIT_ARM         14
`define FPR_BIT_ERROR       13
`define FPR_OP_LSB          0
`define FPR_OP_MSB          3

`define FPR_KEY_FIRST       32'haa996655
`define FPR_KEY_SECOND      32'h556699aa
`define FPR_RESET_WORD      32'h00000000

`define FPR_IRQ_DONE        0
`define FPR_IRQ_ERROR       1
`define FPR_IRQ_REFUSED     2
`define FPR_IRQ_W           3

// cycles after the key pair in which a start is still honoured
`define FPR_UNLOCK_WINDOW   4'h4

`endif

// *** core/fpr_pkg.sv ***
// types shared by the flash register block
package fpr_pkg;

    typedef enum logic [3:0]
    {
        FPR_OP_NONE   = 4'h0,
        FPR_OP_WORD   = 4'h1,
        FPR_OP_ROW    = 4'h3,
        FPR_OP_PAGE   = 4'h4,
        FPR_OP_WHOLE  = 4'h5
    } fpr_op_e;

    typedef enum logic [1:0]
    {
        FPR_LK_IDLE,
        FPR_LK_HALF,
        FPR_LK_OPEN
    } fpr_lock_e;

    typedef enum logic [1:0]
    {
        FPR_SQ_IDLE,
        FPR_SQ_REQ,
        FPR_SQ_WAIT
    } fpr_seq_e;

endpackage

// *** core/fpr_unlock.sv ***
// unlock key sequence tracker: opens a short window after the correct key pair
`timescale 1ns/1ps
`include "fpr_map.svh"

module fpr_unlock
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // key writes and start consumption
    input  wire logic        key_wr_i,
    input  wire logic [31:0] key_data_i,
    input  wire logic        other_wr_i,
    input  wire logic        consume_i,
    // unlocked state
    output logic             open_o
);

    typedef struct packed
    {
        fpr_pkg::fpr_lock_e state;
        logic [3:0]         left;
    } fpr_unlock_s;

    fpr_unlock_s cur;
    fpr_unlock_s next_cur;

    always_comb
    begin
        next_cur = cur;
        unique case (cur.state)
            fpr_pkg::FPR_LK_IDLE:
            begin
                if (key_wr_i && key_data_i == `FPR_KEY_FIRST)
                    next_cur.state = fpr_pkg::FPR_LK_HALF;
            end
            fpr_pkg::FPR_LK_HALF:
            begin
                // key pair must be back to back among register writes
                if (key_wr_i && key_data_i == `FPR_KEY_SECOND)
                begin
                    next_cur.state = fpr_pkg::FPR_LK_OPEN;
                    next_cur.left  = `FPR_UNLOCK_WINDOW;
                end
                else if (key_wr_i || other_wr_i)
                    next_cur.state = fpr_pkg::FPR_LK_IDLE;
            end
            fpr_pkg::FPR_LK_OPEN:
            begin
                next_cur.left = cur.left - 4'h1;
                if (consume_i || cur.left == 4'h1)
                    next_cur.state = fpr_pkg::FPR_LK_IDLE;
            end
            default:
                next_cur.state = fpr_pkg::FPR_LK_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cur.state <= fpr_pkg::FPR_LK_IDLE;
            cur.left  <= 4'h0;
        end
        else
            cur <= next_cur;
    end

    assign open_o = (cur.state == fpr_pkg::FPR_LK_OPEN);

endmodule

// *** core/fpr_top.sv ***
// flash program register block: key, target, data, source registers and sequencer launch
// Summary of operation
// (R1) unlock key register accepts writes; every read returns zero.
// (R2) key pair must be written before any flash operation starts.
// (R3) whole-flash erase ignores the target address register.
// (R4) page erase uses the target address to pick the page.
// (R5) row program writes the row chosen by the target address.
// (R6) word program writes the word chosen by the target address.
// (R7) program data register holds a full 32-bit software value.
// (R8) program data register cleared only by power-on reset.
// (R9) row program fetches data from the source address register.
// (R10) operation codes 1 word, 3 row, 4 page, 5 whole; others none.
// (R11) start bit launches the operation; hardware clears it at completion.
// (R12) start may be set only when arm is set and unlocked.
// (R13) error flag set when a program or erase operation fails.
// (R14) start without a fresh unlock sequence is ignored entirely; here it sets the refused status bit and still records the arm bit.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "fpr_map.svh"

module fpr_top
(
    // clock and resets
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   por_n_i,
    // register port
    input  wire logic [`FPR_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    // flash sequencer handshake
    output logic                        op_req_o,
    output logic      [3:0]             op_code_o,
    output logic      [31:0]            op_addr_o,
    output logic      [31:0]            op_data_o,
    output logic      [31:0]            op_src_o,
    input  wire logic                   op_done_i,
    input  wire logic                   op_fail_i,
    // interrupt
    output logic                        irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed
    {
        fpr_pkg::fpr_seq_e         seq;
        logic                      start;
        logic                      arm;
        logic                      error;
        logic [3:0]                op;
        logic [31:0]               target;
        logic [31:0]               source;
        logic [`FPR_IRQ_W-1:0]     irq_status;
        logic [`FPR_IRQ_W-1:0]     irq_mask;
        logic [31:0]               rdata;
        logic                      req;
        logic [3:0]                code;
        logic [31:0]               addr;
        logic [31:0]               data;
        logic [31:0]               src;
        logic                      irq;
    } fpr_top_s;

    fpr_top_s cur;
    fpr_top_s next_cur;

    // kept apart from the struct: only power-on reset may clear it
    logic [31:0] word_data;
    logic [31:0] next_word_data;

    logic unlock_open;
    logic key_wr;
    logic other_wr;
    logic launch;
    logic start_req;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic fpr_is_op(input logic [3:0] code);
        fpr_is_op = (code == fpr_pkg::FPR_OP_WORD) || (code == fpr_pkg::FPR_OP_ROW)
                 || (code == fpr_pkg::FPR_OP_PAGE) || (code == fpr_pkg::FPR_OP_WHOLE);
    endfunction

    function automatic logic fpr_hit(input logic [`FPR_ADDR_W-1:0] a,
                                     input logic [`FPR_ADDR_W-1:0] off);
        fpr_hit = (a == off);
    endfunction

    // whole erase must not depend on whatever the target register holds
    function automatic logic [31:0] fpr_op_addr(input logic [3:0]  code,
                                                input logic [31:0] target);
        fpr_op_addr = (code == fpr_pkg::FPR_OP_WHOLE) ? 32'h00000000 : target;
    endfunction

    // only a row program reads from system memory
    function automatic logic [31:0] fpr_op_src(input logic [3:0]  code,
                                               input logic [31:0] source);
        fpr_op_src = (code == fpr_pkg::FPR_OP_ROW) ? source : 32'h00000000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // unlock tracking

    assign key_wr   = wr_i && fpr_hit(addr_i, `FPR_OFF_KEY);
    // any other write between the two key words breaks the pair
    assign other_wr = wr_i && !key_wr;

    // (R2) key sequence tracker
    fpr_unlock u_unlock
    (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .key_wr_i   (key_wr),
        .key_data_i (wdata_i),
        .other_wr_i (other_wr),
        .consume_i  (launch),
        .open_o     (unlock_open)
    );

    assign start_req = wr_i && fpr_hit(addr_i, `FPR_OFF_CONTROL) && wdata_i[`FPR_BIT_START];
    // (R12) arm set and unlocked
    assign launch = start_req && cur.arm && unlock_open && !cur.start;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_cur       = cur;
        next_word_data = word_data;
        next_cur.req   = 1'b0;

        // read clears status first, so an event in the same cycle still lands
        if (rd_i && fpr_hit(addr_i, `FPR_OFF_IRQ_STATUS))
            next_cur.irq_status = '0;

        if (wr_i)
        begin
            if (fpr_hit(addr_i, `FPR_OFF_CONTROL))
            begin
                // a refused start still records the arm bit written with it
                next_cur.arm = wdata_i[`FPR_BIT_ARM];
                // operation select only changes while disarmed and idle
                if (!cur.arm && !cur.start)
                    next_cur.op = wdata_i[`FPR_OP_MSB:`FPR_OP_LSB];
            end
            // writes while busy are dropped so the running operation sees fixed values
            if (fpr_hit(addr_i, `FPR_OFF_TARGET) && !cur.start)
                next_cur.target = wdata_i;
            // (R7) full word store
            if (fpr_hit(addr_i, `FPR_OFF_DATA) && !cur.start)
                next_word_data = wdata_i;
            if (fpr_hit(addr_i, `FPR_OFF_SOURCE) && !cur.start)
                next_cur.source = wdata_i;
            if (fpr_hit(addr_i, `FPR_OFF_IRQ_MASK))
                next_cur.irq_mask = wdata_i[`FPR_IRQ_W-1:0];
        end

        // (R14) refused start sets the refused status bit; the arm bit written with it is still recorded
        if (start_req && !launch && !cur.start)
            next_cur.irq_status[`FPR_IRQ_REFUSED] = 1'b1;

        // (R11) launch operation
        if (launch)
        begin
            next_cur.start = 1'b1;
            next_cur.error = 1'b0;
            if (fpr_is_op(cur.op))
            begin
                next_cur.seq  = fpr_pkg::FPR_SQ_REQ;
                next_cur.req  = 1'b1;
                next_cur.code = cur.op;
                // (R3) whole erase ignores target
                // (R4) page erase target
                // (R5) row program target
                // (R6) word program target
                next_cur.addr = fpr_op_addr(cur.op, cur.target);
                // captured here, later data writes cannot disturb the operation
                next_cur.data = word_data;
                // (R9) row source address
                next_cur.src  = fpr_op_src(cur.op, cur.source);
            end
            else
            begin
                // (R10) no operation completes on the next cycle without the sequencer, clearing the error
                next_cur.seq = fpr_pkg::FPR_SQ_IDLE;
            end
        end

        if (cur.start && cur.seq == fpr_pkg::FPR_SQ_IDLE)
        begin
            next_cur.start = 1'b0;
            next_cur.irq_status[`FPR_IRQ_DONE] = 1'b1;
        end

        unique case (cur.seq)
            fpr_pkg::FPR_SQ_IDLE:
            begin
            end
            fpr_pkg::FPR_SQ_REQ, fpr_pkg::FPR_SQ_WAIT:
            begin
                next_cur.seq = fpr_pkg::FPR_SQ_WAIT;
                if (op_done_i)
                begin
                    // (R11) hardware clears start
                    next_cur.start = 1'b0;
                    next_cur.seq   = fpr_pkg::FPR_SQ_IDLE;
                    next_cur.irq_status[`FPR_IRQ_DONE] = 1'b1;
                    // (R13) failure flag
                    if (op_fail_i)
                    begin
                        next_cur.error = 1'b1;
                        next_cur.irq_status[`FPR_IRQ_ERROR] = 1'b1;
                    end
                end
            end
            default:
            begin
                // unused code: fall back to idle rather than hang
                next_cur.seq = fpr_pkg::FPR_SQ_IDLE;
            end
        endcase

        // read data, one cycle later
        next_cur.rdata = 32'h00000000;
        if (rd_i)
        begin
            unique case (addr_i)
                `FPR_OFF_CONTROL:
                begin
                    next_cur.rdata[`FPR_BIT_START]             = cur.start;
                    next_cur.rdata[`FPR_BIT_ARM]               = cur.arm;
                    next_cur.rdata[`FPR_BIT_ERROR]             = cur.error;
                    next_cur.rdata[`FPR_OP_MSB:`FPR_OP_LSB]    = cur.op;
                end
                // (R1) key reads as zero
                `FPR_OFF_KEY:        next_cur.rdata = 32'h00000000;
                `FPR_OFF_TARGET:     next_cur.rdata = cur.target;
                `FPR_OFF_DATA:       next_cur.rdata = word_data;
                `FPR_OFF_SOURCE:     next_cur.rdata = cur.source;
                `FPR_OFF_IRQ_STATUS:
                begin
                    next_cur.rdata[`FPR_IRQ_W-1:0] = cur.irq_status;
                end
                `FPR_OFF_IRQ_MASK:   next_cur.rdata[`FPR_IRQ_W-1:0] = cur.irq_mask;
                default:             next_cur.rdata = 32'h00000000;
            endcase
        end

        // level output, registered like every other output
        next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cur.seq        <= fpr_pkg::FPR_SQ_IDLE;
            cur.start      <= 1'b0;
            cur.arm        <= 1'b0;
            cur.error      <= 1'b0;
            cur.op         <= 4'h0;
            cur.target     <= `FPR_RESET_WORD;
            cur.source     <= `FPR_RESET_WORD;
            cur.irq_status <= '0;
            cur.irq_mask   <= '0;
            cur.rdata      <= 32'h00000000;
            cur.req        <= 1'b0;
            cur.code       <= 4'h0;
            cur.addr       <= 32'h00000000;
            cur.data       <= 32'h00000000;
            cur.src        <= 32'h00000000;
            cur.irq        <= 1'b0;
        end
        else
            cur <= next_cur;
    end

    // (R8) power-on reset only
    always_ff @(posedge clk_i)
    begin
        if (!por_n_i)
            word_data <= `FPR_RESET_WORD;
        else
            word_data <= next_word_data;
    end

    assign rdata_o   = cur.rdata;
    assign op_req_o  = cur.req;
    assign op_code_o = cur.code;
    assign op_addr_o = cur.addr;
    assign op_data_o = cur.data;
    assign op_src_o  = cur.src;
    assign irq_o     = cur.irq;

endmodule

// *** verif/fpr_top_asserts.sv ***
// port assertions for the flash register block
`timescale 1ns/1ps
`include "fpr_map.svh"

module fpr_top_asserts
(
    // clock, resets and register port
    input wire logic                   clk_i,
    input wire logic                   reset_n_i,
    input wire logic                   por_n_i,
    input wire logic [`FPR_ADDR_W-1:0] addr_i,
    input wire logic [31:0]            wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [31:0]            rdata_o,
    // sequencer side and interrupt
    input wire logic                   op_req_o,
    input wire logic [3:0]             op_code_o,
    input wire logic [31:0]            op_addr_o,
    input wire logic [31:0]            op_data_o,
    input wire logic [31:0]            op_src_o,
    input wire logic                   op_done_i,
    input wire logic                   op_fail_i,
    input wire logic                   irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // cycles since the second key word; loose on purpose, any such write restarts it
    logic [2:0] key_age;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            key_age <= 3'h7;
        else if (wr_i && addr_i == `FPR_OFF_KEY && wdata_i == `FPR_KEY_SECOND)
            key_age <= 3'h0;
        else if (key_age != 3'h7)
            key_age <= key_age + 3'h1;
    end

    property p_key_zero;
        rd_i && addr_i == `FPR_OFF_KEY |=> rdata_o == 32'h0;
    endproperty
    a_key_zero: assert property (p_key_zero)
        else $error("key register read not zero");
    property p_rd_idle;
        !rd_i |=> rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_whole;
        op_req_o && op_code_o == 4'h5 |-> op_addr_o == 32'h0;
    endproperty
    a_whole: assert property (p_whole)
        else $error("whole erase carries an address");
    property p_src;
        op_req_o && op_code_o != 4'h3 |-> op_src_o == 32'h0;
    endproperty
    a_src: assert property (p_src)
        else $error("source address on non row launch");
    property p_pulse;
        op_req_o |=> !op_req_o;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("launch longer than one cycle");
    property p_codes;
        op_req_o |-> op_code_o inside {4'h1, 4'h3, 4'h4, 4'h5};
    endproperty
    a_codes: assert property (p_codes)
        else $error("launch with a no-operation code");
    property p_cause;
        $rose(op_req_o) |-> $past(wr_i) && $past(addr_i) == `FPR_OFF_CONTROL
            && $past(wdata_i[`FPR_BIT_START]);
    endproperty
    a_cause: assert property (p_cause)
        else $error("launch without a start write");
    property p_unlock;
        op_req_o |-> key_age <= 3'h5;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("launch without a fresh key pair");

    c_row: cover property (op_req_o && op_code_o == 4'h3);
    c_irq: cover property ($rose(irq_o));
    c_fail: cover property (op_done_i && op_fail_i);
endmodule

////////////////////////////////////////////////////////////////////////////////
bind fpr_top fpr_top_asserts u_asserts
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .op_req_o(op_req_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
    .op_data_o(op_data_o), .op_src_o(op_src_o), .op_done_i(op_done_i),
    .op_fail_i(op_fail_i), .irq_o(irq_o)
);

// *** verif/tb_top.sv ***
// self-checking bench for the flash register block
`timescale 1ns/1ps
`include "fpr_map.svh"

module tb_top;
    logic                   clk_i     = 1'b0;
    logic                   reset_n_i = 1'b0;
    logic                   por_n_i   = 1'b0;
    logic [`FPR_ADDR_W-1:0] addr_i    = '0;
    logic [31:0]            wdata_i   = 32'h0;
    logic                   wr_i      = 1'b0;
    logic                   rd_i      = 1'b0;
    logic                   op_done_i = 1'b0;
    logic                   op_fail_i = 1'b0;
    logic [31:0]            rdata_o;
    logic                   op_req_o;
    logic [3:0]             op_code_o;
    logic [31:0]            op_addr_o;
    logic [31:0]            op_data_o;
    logic [31:0]            op_src_o;
    logic                   irq_o;
    int                     err_count    = 0;
    int                     total_checks = 0;
    logic [3:0]             ops [4]      = '{4'h1, 4'h3, 4'h4, 4'h5};

    fpr_top uut
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .op_req_o(op_req_o), .op_code_o(op_code_o), .op_addr_o(op_addr_o),
        .op_data_o(op_data_o), .op_src_o(op_src_o), .op_done_i(op_done_i),
        .op_fail_i(op_fail_i), .irq_o(irq_o)
    );

    always #20 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [`FPR_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [`FPR_ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 check(rdata_o, exp);
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq_o !== v && n < 8)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        check({31'h0, irq_o}, {31'h0, v});
        if (irq_o !== v)
            tally_and_finish();
    endtask

    // full unlocked launch, completion and interrupt
    task automatic launch(input logic [3:0] op, input logic fail);
        wr(`FPR_OFF_CONTROL, {28'h0, op});
        wr(`FPR_OFF_CONTROL, {16'h0, 16'h4000} + {28'h0, op});
        wr(`FPR_OFF_KEY, `FPR_KEY_FIRST);
        wr(`FPR_OFF_KEY, `FPR_KEY_SECOND);
        wr(`FPR_OFF_CONTROL, {16'h0, 16'hc000} + {28'h0, op});
        #1 check({31'h0, op_req_o}, 32'h1);
        check({28'h0, op_code_o}, {28'h0, op});
        check(op_addr_o, (op == 4'h5) ? 32'h0 : 32'h1a40);
        check(op_data_o, 32'ha5c30f96);
        check(op_src_o, (op == 4'h3) ? 32'h1d000200 : 32'h0);
        rd(`FPR_OFF_CONTROL, {16'h0, 16'hc000} + {28'h0, op});
        @(posedge clk_i);
        op_done_i <= 1'b1;
        op_fail_i <= fail;
        @(posedge clk_i);
        op_done_i <= 1'b0;
        op_fail_i <= 1'b0;
        rd(`FPR_OFF_CONTROL, {16'h0, 2'h1, fail, 13'h0} + {28'h0, op});
        check({31'h0, irq_o}, 32'h1);
        rd(`FPR_OFF_IRQ_STATUS, {30'h0, fail, 1'b1});
        wait_irq(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // reset values, key read-back, unmapped address, data store
    task automatic reg_access;
        rd(`FPR_OFF_TARGET, 32'h0);
        rd(`FPR_OFF_DATA, 32'h0);
        rd(`FPR_OFF_SOURCE, 32'h0);
        wr(`FPR_OFF_KEY, 32'h5a5a1234);
        rd(`FPR_OFF_KEY, 32'h0);
        wr(6'h1c, 32'hffffffff);
        rd(6'h1c, 32'h0);
        wr(`FPR_OFF_TARGET, 32'h77);
        wr(`FPR_OFF_DATA, 32'ha5c30f96);
        rd(`FPR_OFF_DATA, 32'ha5c30f96);
    endtask

    // device reset only: data word survives, target does not
    task automatic device_reset;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(`FPR_OFF_DATA, 32'ha5c30f96);
        rd(`FPR_OFF_TARGET, 32'h0);
    endtask

    // every real operation, the page erase failing
    task automatic launch_all;
        wr(`FPR_OFF_TARGET, 32'h1a40);
        wr(`FPR_OFF_SOURCE, 32'h1d000200);
        wr(`FPR_OFF_IRQ_MASK, 32'h7);
        foreach (ops[i])
            launch(ops[i], ops[i] == 4'h4);
    endtask

    // starts without key pair, without arm, after the key window; refusal masked
    task automatic refused_start;
        wr(`FPR_OFF_IRQ_MASK, 32'h3);
        wr(`FPR_OFF_CONTROL, 32'hc005);
        #1 check({31'h0, op_req_o}, 32'h0);
        rd(`FPR_OFF_CONTROL, 32'h4005);
        check({31'h0, irq_o}, 32'h0);
        rd(`FPR_OFF_IRQ_STATUS, 32'h4);
        wr(`FPR_OFF_CONTROL, 32'h1);
        wr(`FPR_OFF_KEY, `FPR_KEY_FIRST);
        wr(`FPR_OFF_KEY, `FPR_KEY_SECOND);
        wr(`FPR_OFF_CONTROL, 32'h8001);
        #1 check({31'h0, op_req_o}, 32'h0);
        rd(`FPR_OFF_CONTROL, 32'h1);
        rd(`FPR_OFF_IRQ_STATUS, 32'h4);
        wr(`FPR_OFF_CONTROL, 32'h4001);
        wr(`FPR_OFF_KEY, `FPR_KEY_FIRST);
        wr(`FPR_OFF_KEY, `FPR_KEY_SECOND);
        repeat (4) @(posedge clk_i);
        wr(`FPR_OFF_CONTROL, 32'hc001);
        #1 check({31'h0, op_req_o}, 32'h0);
        rd(`FPR_OFF_CONTROL, 32'h4001);
        rd(`FPR_OFF_IRQ_STATUS, 32'h4);
    endtask

    // no-operation code: start clears itself, nothing reaches the sequencer
    task automatic noop_start;
        wr(`FPR_OFF_CONTROL, 32'h0);
        wr(`FPR_OFF_CONTROL, 32'h4000);
        wr(`FPR_OFF_KEY, `FPR_KEY_FIRST);
        wr(`FPR_OFF_KEY, `FPR_KEY_SECOND);
        wr(`FPR_OFF_CONTROL, 32'hc000);
        #1 check({31'h0, op_req_o}, 32'h0);
        rd(`FPR_OFF_CONTROL, 32'h4000);
        check({31'h0, irq_o}, 32'h1);
        rd(`FPR_OFF_IRQ_STATUS, 32'h1);
    endtask

    // power-on reset clears the data word
    task automatic power_on_reset;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        por_n_i   <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        por_n_i   <= 1'b1;
        rd(`FPR_OFF_DATA, 32'h0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        por_n_i   <= 1'b1;
        reg_access();
        device_reset();
        launch_all();
        refused_start();
        noop_start();
        power_on_reset();
        tally_and_finish();
    end
endmodule
